// *** rtl/rre_pkg.sv ***
// Notes on behaviour
// - return pops stack into pc, two cycles
// - restore bit set copies three shadows back
// - restore bit clear leaves working, status, bank
// - return never touches pc latches
// - carry rotates update carry, negative, zero
// - plain left rotate: bit7 into bit0
// - plain rotates update only negative, zero
// - right through carry: bit0 to carry
// - destination bit picks working or file
// - bank bit picks access or selected bank
// - extended set, access bank low address uses indexed offset
// - rotates take one cycle, four phases
package rre_pkg;
   // ==========================================
   // opcode fields
   localparam logic [15:0] RET_MASK = 16'hFFFE;
   localparam logic [15:0] RET_CODE = 16'h0012;
   localparam logic [5:0] OP_RL_CARRY = 6'h0D;
   localparam logic [5:0] OP_RR_CARRY = 6'h0C;
   localparam logic [5:0] OP_RL_PLAIN = 6'h11;
   localparam logic [5:0] OP_RR_PLAIN = 6'h10;
   localparam int DEST_BIT = 9;
   localparam int BANK_BIT = 8;
   localparam int RESTORE_BIT = 0;
   // ==========================================
   // status bits and addressing
   localparam int ST_C = 0;
   localparam int ST_Z = 2;
   localparam int ST_N = 4;
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   // ==========================================
   // reset values
   localparam logic [20:0] PC_RESET = 21'h000000;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [3:0] BANK_RESET = 4'h0;
   localparam logic [1:0] PHASE_RESET = 2'h0;
   typedef enum logic [1:0] {RRE_Q1, RRE_Q2, RRE_Q3, RRE_Q4} rre_phase_e;
   typedef enum {RRE_ROT_LC, RRE_ROT_RC, RRE_ROT_LP, RRE_ROT_RP} rre_rot_e;
   typedef struct packed {
      logic [7:0] data;
      logic carry;
      logic zero;
      logic neg;
   } rre_rot_s;
   typedef struct packed {
      logic [7:0] working;
      logic [7:0] status;
      logic [3:0] bank;
   } rre_shadow_s;
endpackage

// *** rtl/rre_rotator.sv ***
`timescale 1ns/1ps
// ==========================================
// byte rotator with flag results
module rre_rotator (
   // operand
   input wire logic [7:0] operand,
   input wire logic carry_in,
   input wire logic [1:0] kind,
   // result
   output rre_pkg::rre_rot_s result
);
   logic [7:0] r;
   logic c;
   // select shift form
   always_comb begin
      r = operand;
      c = carry_in;
      unique case (kind)
         2'h0: begin
            r = {operand[6:0], carry_in};
            c = operand[7];
         end
         2'h1: begin
            r = {carry_in, operand[7:1]};
            c = operand[0];
         end
         2'h2: r = {operand[6:0], operand[7]};
         2'h3: r = {operand[0], operand[7:1]};
      endcase
   end
   assign result.data = r;
   assign result.carry = c;
   assign result.zero = (r == 8'h00);
   assign result.neg = r[7];
endmodule

// *** rtl/rre_exec.sv ***
`timescale 1ns/1ps
// ==========================================
// return and rotate execution slice
module rre_exec (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // instruction
   input wire logic [15:0] opcode,
   input wire logic op_valid,
   input wire logic ext_enable,
   // return stack
   input wire logic [20:0] stack_top_value,
   output logic stack_pop,
   // shadows
   input rre_pkg::rre_shadow_s shadow_in,
   // data memory
   output logic [11:0] mem_addr,
   output logic mem_rd,
   input wire logic [7:0] mem_rdata,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] index_base,
   // core state
   output logic [20:0] pc,
   output logic [7:0] working_reg,
   output logic [7:0] status_reg,
   output logic [3:0] bank_select_reg,
   output logic [7:0] pc_upper_latch,
   output logic [7:0] pc_high_latch,
   output logic fetch_flush,
   output logic busy
);
   rre_pkg::rre_phase_e phase_reg;
   logic [15:0] ir_reg;
   logic ret_second_reg;
   logic [7:0] operand_reg;
   logic [7:0] result_reg;
   logic [1:0] kind;
   logic is_ret, is_rot;
   rre_pkg::rre_rot_s rot;
   logic [7:0] faddr;

   // ==========================================
   // decode
   assign is_ret = ((ir_reg & rre_pkg::RET_MASK) == rre_pkg::RET_CODE);
   always_comb begin
      is_rot = 1'b1;
      kind = 2'h0;
      unique case (ir_reg[15:10])
         rre_pkg::OP_RL_CARRY: kind = 2'h0;
         rre_pkg::OP_RR_CARRY: kind = 2'h1;
         rre_pkg::OP_RL_PLAIN: kind = 2'h2;
         rre_pkg::OP_RR_PLAIN: kind = 2'h3;
         default: is_rot = 1'b0;
      endcase
   end
   assign faddr = ir_reg[7:0];

   // address: access bank, indexed, or banked
   always_comb begin
      if (ir_reg[rre_pkg::BANK_BIT]) begin
         mem_addr = {bank_select_reg, faddr};
      end else if (ext_enable && faddr <= rre_pkg::INDEXED_LIMIT) begin
         // base plus offset wraps inside the low page
         mem_addr = {4'h0, 8'(index_base + faddr)};
      end else if (faddr < rre_pkg::ACCESS_SPLIT) begin
         mem_addr = {4'h0, faddr};
      end else begin
         mem_addr = {rre_pkg::ACCESS_HI_BANK, faddr};
      end
   end

   // ==========================================
   // phase counter; the word loads at the end of q4
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase_reg <= rre_pkg::RRE_Q1;
      end else begin
         phase_reg <= rre_pkg::rre_phase_e'(phase_reg + 2'h1);
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ir_reg <= 16'h0000;
      end else if (phase_reg == rre_pkg::RRE_Q4) begin
         // second return cycle ignores fetched word
         ir_reg <= (op_valid && !(is_ret && !ret_second_reg)) ? opcode : 16'h0000;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ret_second_reg <= 1'b0;
      end else if (phase_reg == rre_pkg::RRE_Q4) begin
         ret_second_reg <= is_ret && !ret_second_reg;
      end
   end

   // ==========================================
   // rotate datapath: read q2, compute q3, write q4
   rre_rotator u_rot (
      .operand(operand_reg),
      .carry_in(status_reg[rre_pkg::ST_C]),
      .kind(kind),
      .result(rot)
   );

   assign mem_rd = is_rot && !ret_second_reg && phase_reg == rre_pkg::RRE_Q2;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         operand_reg <= rre_pkg::BYTE_RESET;
         result_reg <= rre_pkg::BYTE_RESET;
      end else begin
         if (mem_rd) operand_reg <= mem_rdata;
         if (phase_reg == rre_pkg::RRE_Q3) result_reg <= rot.data;
      end
   end

   assign mem_wr = is_rot && !ret_second_reg && phase_reg == rre_pkg::RRE_Q4
      && ir_reg[rre_pkg::DEST_BIT];
   assign mem_wdata = result_reg;

   // ==========================================
   // working, status, bank updates
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         working_reg <= rre_pkg::BYTE_RESET;
         status_reg <= rre_pkg::BYTE_RESET;
         bank_select_reg <= rre_pkg::BANK_RESET;
      end else if (phase_reg == rre_pkg::RRE_Q3 && !ret_second_reg) begin
         if (is_ret && ir_reg[rre_pkg::RESTORE_BIT]) begin
            working_reg <= shadow_in.working;
            status_reg <= shadow_in.status;
            bank_select_reg <= shadow_in.bank;
         end else if (is_rot) begin
            // q3 result; file write lands in q4
            if (!ir_reg[rre_pkg::DEST_BIT]) working_reg <= rot.data;
            status_reg[rre_pkg::ST_N] <= rot.neg;
            status_reg[rre_pkg::ST_Z] <= rot.zero;
            if (!kind[1]) status_reg[rre_pkg::ST_C] <= rot.carry;
         end
         // restore clear: values held
      end
   end

   // ==========================================
   // program counter and latches
   assign stack_pop = is_ret && !ret_second_reg && phase_reg == rre_pkg::RRE_Q4;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc <= rre_pkg::PC_RESET;
      end else if (stack_pop) begin
         pc <= stack_top_value;
      end else if (phase_reg == rre_pkg::RRE_Q4) begin
         pc <= pc + 21'h2;
      end
   end

   // latches owned elsewhere; held at reset value here
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_upper_latch <= rre_pkg::BYTE_RESET;
         pc_high_latch <= rre_pkg::BYTE_RESET;
      end else begin
         pc_upper_latch <= pc_upper_latch;
         pc_high_latch <= pc_high_latch;
      end
   end

   assign fetch_flush = stack_pop;
   assign busy = ret_second_reg;
endmodule

// *** verification/rre_exec_properties.sv ***
`timescale 1ns/1ps
// ==========================================
// port checks on the exec slice
module rre_exec_properties (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // watched ports
   input wire logic [20:0] stack_top_value,
   input wire logic stack_pop,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [20:0] pc,
   input wire logic [7:0] status_reg,
   input wire logic [3:0] bank_select_reg,
   input wire logic [7:0] pc_upper_latch,
   input wire logic [7:0] pc_high_latch,
   input wire logic fetch_flush,
   input wire logic busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // forced idle cycle after a return, four quiet phases
   sequence idle_phase;
      busy && !mem_rd && !mem_wr;
   endsequence
   sequence ret_tail;
      idle_phase [*4];
   endsequence
   chk_pop_loads_pc: assert property (stack_pop |=> pc == $past(stack_top_value))
      else $error("pc not loaded from popped value");
   chk_ret_idle_tail: assert property (stack_pop |=> ret_tail)
      else $error("second return cycle not idle");
   chk_latch_fixed: assert property (pc_upper_latch == 8'h00 && pc_high_latch == 8'h00)
      else $error("pc latch modified");
   chk_flush_on_pop: assert property (fetch_flush == stack_pop)
      else $error("flush and pop differ");
   chk_wr_after_rd: assert property (mem_wr |-> $past(mem_rd, 2) && !stack_pop)
      else $error("write not two phases after read");
   chk_rd_alone: assert property (mem_rd |-> !mem_wr && !busy)
      else $error("read overlaps write or idle cycle");
   chk_bank_on_ret: assert property ($changed(bank_select_reg) |-> stack_pop)
      else $error("bank select changed outside return");
   chk_dc_ov_held: assert property ($changed({status_reg[3], status_reg[1]}) |-> stack_pop)
      else $error("digit carry or overflow touched");
endmodule
bind rre_exec rre_exec_properties u_props (.clk, .nrst, .stack_top_value, .stack_pop, .mem_rd,
   .mem_wr, .pc, .status_reg, .bank_select_reg, .pc_upper_latch, .pc_high_latch, .fetch_flush,
   .busy);

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
// ==========================================
// exec slice bench
module testbench;
   logic clk, nrst, op_valid, ext_enable, stack_pop, mem_rd, mem_wr, fetch_flush, busy;
   logic [15:0] opcode;
   logic [20:0] stack_top_value, pc;
   logic [7:0] mem_rdata, mem_wdata, index_base, working_reg, status_reg, pcu, pch, w, st;
   logic [11:0] mem_addr;
   logic [3:0] bank_select_reg, b;
   rre_pkg::rre_shadow_s shadow_in;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [5:0] ops [4] = '{rre_pkg::OP_RL_CARRY, rre_pkg::OP_RR_CARRY,
      rre_pkg::OP_RL_PLAIN, rre_pkg::OP_RR_PLAIN};
   rre_exec dut (.clk, .nrst, .opcode, .op_valid, .ext_enable, .stack_top_value, .stack_pop,
      .shadow_in, .mem_addr, .mem_rd, .mem_rdata, .mem_wr, .mem_wdata, .index_base, .pc,
      .working_reg, .status_reg, .bank_select_reg, .pc_upper_latch(pcu), .pc_high_latch(pch),
      .fetch_flush, .busy);
   // free-running core clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard, far above the ~150 cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         final_report;
      end
   end
   task automatic final_report;
      $display("checks %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // one rotate after an idle word; kind 0..3 is left carry, right carry, left plain,
   // right plain; entered mid Q4, offered at the edge opening Q4, checked mid Q2 and Q4
   task automatic rot(input int k, input logic d, input logic a, input logic [7:0] f,
      input logic [7:0] v, input logic [11:0] adr);
      logic [7:0] r;
      logic c;
      c = st[0];
      case (k)
         0: {c, r} = {v, st[0]};
         1: {r, c} = {st[0], v};
         2: r = {v[6:0], v[7]};
         default: r = {v[0], v[7:1]};
      endcase
      repeat (4) @(posedge clk);
      opcode <= {ops[k], d, a, f};
      op_valid <= 1'b1;
      mem_rdata <= v;
      @(posedge clk);
      op_valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      `CHK(mem_rd, 1'b1)
      `CHK(mem_addr, adr)
      repeat (2) @(posedge clk);
      @(negedge clk);
      st[0] = c;
      st[2] = (r == 8'h00);
      st[4] = r[7];
      if (!d) w = r;
      `CHK(mem_wr, d)
      if (d) `CHK(mem_wdata, r)
      `CHK(working_reg, w)
      `CHK(status_reg, st)
   endtask
   // return after an idle word; a rotate offered in its Q4 must be dropped
   task automatic ret(input logic s);
      repeat (4) @(posedge clk);
      opcode <= rre_pkg::RET_CODE | {15'h0000, s};
      op_valid <= 1'b1;
      stack_top_value <= 21'h1A2B3C + 21'(s);
      // clear restore gets fresh shadows so a wrong copy would show
      if (s) shadow_in <= '{working: 8'h5A, status: 8'h0B, bank: 4'h3};
      else shadow_in <= '{working: 8'hC3, status: 8'h00, bank: 4'h7};
      @(posedge clk);
      op_valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      `CHK(mem_rd, 1'b0)
      repeat (2) @(posedge clk);
      opcode <= {rre_pkg::OP_RL_PLAIN, 2'b00, 8'h20};
      op_valid <= 1'b1;
      mem_rdata <= 8'h81;
      @(negedge clk);
      if (s) begin
         w = shadow_in.working;
         st = shadow_in.status;
         b = shadow_in.bank;
      end
      `CHK(stack_pop, 1'b1)
      `CHK(fetch_flush, 1'b1)
      `CHK(working_reg, w)
      `CHK(status_reg, st)
      `CHK(bank_select_reg, b)
      `CHK({pcu, pch}, 16'h0000)
      @(posedge clk);
      op_valid <= 1'b0;
      @(negedge clk);
      `CHK(pc, stack_top_value)
      `CHK(busy, 1'b1)
      repeat (3) @(posedge clk);
      @(negedge clk);
      `CHK(working_reg, w)
   endtask
   // reset, then returns and rotates across all addressing cases
   initial begin
      nrst = 1'b0;
      op_valid = 1'b0;
      opcode = 16'h0000;
      ext_enable = 1'b0;
      stack_top_value = 21'h000000;
      mem_rdata = 8'h00;
      index_base = 8'h30;
      w = 8'h00;
      st = 8'h00;
      b = 4'h0;
      shadow_in = '{working: 8'h5A, status: 8'h0B, bank: 4'h3};
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      // every scenario is entered mid Q4 of a word
      repeat (3) @(posedge clk);
      @(negedge clk);
      ret(1'b1);
      ret(1'b0);
      for (int k = 0; k < 4; k++) begin
         rot(k, 1'b1, 1'b1, 8'h10, 8'h80, 12'h310);
         rot(k, 1'b0, 1'b1, 8'h11, 8'h01, 12'h311);
      end
      rot(2, 1'b0, 1'b0, 8'h60, 8'h3C, 12'hF60);
      rot(2, 1'b0, 1'b0, 8'h5F, 8'h3C, 12'h05F);
      // one idle word lets the extended set switch on at an edge
      @(posedge clk);
      ext_enable <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rot(3, 1'b0, 1'b0, 8'h5F, 8'h00, 12'h08F);
      rot(3, 1'b1, 1'b0, 8'h60, 8'h02, 12'hF60);
      rot(0, 1'b0, 1'b1, 8'h05, 8'h7F, 12'h305);
      final_report;
   end
endmodule
